// ### sep_core.sv
// Command engine of a two-wire serial EEPROM slave with AXI4-Lite side registers.
// Assumes scl, sda and write-protect arrive asynchronously from pins;
// sda is open drain, resolved outside from sda_oe.
`timescale 1ns/1ps
module sep_core #(
    parameter int WRITE_CYCLES = sep_pkg::TWC_CYCLES,
    parameter logic [3:0] DEV_TYPE = sep_pkg::DEV_CODE
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp_in,
    // AXI4-Lite write
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sep_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [sep_pkg::AXI_AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam int AW = sep_pkg::MEM_AW;

    function automatic logic [1:0] reg_sel(input logic [sep_pkg::AXI_AW-1:0] a);
        logic [1:0] s;
        s = sep_pkg::SEL_NONE;
        if (a == sep_pkg::REG_CTRL) begin
            s = sep_pkg::SEL_CTRL;
        end else if (a == sep_pkg::REG_STAT) begin
            s = sep_pkg::SEL_STAT;
        end
        return s;
    endfunction

    // Pin synchronisers; s3 only serves edge detection
    sep_pkg::sep_line_type s1_q, s2_q, s3_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= '{scl: scl_in, sda: sda_in, wp: wp_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, wp_eff, busy;
    logic [1:0] ctrl_q, ctrl_d;

    assign scl_rise = s2_q.scl & ~s3_q.scl;
    assign scl_fall = ~s2_q.scl & s3_q.scl;
    assign start_det = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
    assign stop_det = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
    assign wp_eff = s2_q.wp | ctrl_q[sep_pkg::CTRL_SWP];

    // Protocol state
    sep_pkg::sep_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic ack_q, ack_d;
    logic mack_q, mack_d;
    logic oe_q, oe_d;
    logic pend_q, pend_d;
    logic [AW-1:0] ptr_q, ptr_d;
    logic [1:0] blk_q, blk_d;
    logic [sep_pkg::PAGE_BYTES-1:0] vmask_q, vmask_d;
    logic [sep_pkg::PAGE_BYTES-1:0][7:0] pbuf_q, pbuf_d;
    logic [sep_pkg::PAGE_AW-1:0] idx_q, idx_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_rd;

    assign busy = (st_q == sep_pkg::ST_COMMIT) || (st_q == sep_pkg::ST_WAIT);
    assign mem_we = (st_q == sep_pkg::ST_COMMIT) && vmask_q[idx_q] && !wp_eff;
    assign mem_addr = (st_q == sep_pkg::ST_COMMIT) ? {ptr_q[AW-1:sep_pkg::PAGE_AW], idx_q}
                                                   : ptr_q;

    sep_mem #(
        .AW(AW),
        .DW(8)
    ) u_mem (
        .clk(aclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(pbuf_q[idx_q]),
        .rdata_q(mem_rd)
    );

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ack_d = ack_q;
        mack_d = mack_q;
        pend_d = pend_q;
        ptr_d = ptr_q;
        blk_d = blk_q;
        vmask_d = vmask_q;
        pbuf_d = pbuf_q;
        idx_d = idx_q;
        tmr_d = tmr_q;
        case (st_q)
            // Bus is ignored entirely while programming
            sep_pkg::ST_COMMIT: begin
                tmr_d = tmr_q + TW'(1);
                idx_d = idx_q + 4'h1;
                if (idx_q == 4'hF) begin
                    st_d = sep_pkg::ST_WAIT;
                end
            end
            sep_pkg::ST_WAIT: begin
                tmr_d = tmr_q + TW'(1);
                if (tmr_q >= TW'(WRITE_CYCLES - 1)) begin
                    st_d = sep_pkg::ST_IDLE;
                    vmask_d = '0;
                    pend_d = 1'b0;
                end
            end
            default: begin
                if (start_det) begin
                    st_d = sep_pkg::ST_CTRL;
                    cnt_d = 4'h0;
                    ack_d = 1'b0;
                    vmask_d = '0;
                    pend_d = 1'b0;
                end else if (stop_det) begin
                    ack_d = 1'b0;
                    if (st_q == sep_pkg::ST_WDATA && pend_q && !wp_eff) begin
                        st_d = sep_pkg::ST_COMMIT;
                        idx_d = 4'h0;
                        tmr_d = '0;
                    end else begin
                        st_d = sep_pkg::ST_IDLE;
                        vmask_d = '0;
                        pend_d = 1'b0;
                    end
                end else if (st_q == sep_pkg::ST_READ) begin
                    if (scl_fall && cnt_q < sep_pkg::BIT_ACK) begin
                        tx_d = {tx_q[6:0], 1'b1};
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == sep_pkg::BIT_LAST) begin
                            ptr_d = ptr_q + 10'h001;
                        end
                    end else if (scl_rise && cnt_q == sep_pkg::BIT_ACK) begin
                        mack_d = ~s2_q.sda;
                    end else if (scl_fall && cnt_q == sep_pkg::BIT_ACK) begin
                        if (mack_q) begin
                            tx_d = mem_rd;
                            cnt_d = 4'h0;
                        end else begin
                            st_d = sep_pkg::ST_IDLE;
                        end
                    end
                end else if (st_q != sep_pkg::ST_IDLE) begin
                    if (scl_rise && cnt_q < sep_pkg::BIT_ACK) begin
                        sh_d = {sh_q[6:0], s2_q.sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == sep_pkg::BIT_ACK) begin
                        cnt_d = sep_pkg::BIT_END;
                        if (st_q == sep_pkg::ST_CTRL) begin
                            if (sh_q[7:sep_pkg::CB_CODE] == DEV_TYPE
                                && ctrl_q[sep_pkg::CTRL_EN]) begin
                                ack_d = 1'b1;
                                blk_d = sh_q[sep_pkg::CB_MID:sep_pkg::CB_LOW];
                                ptr_d = {sh_q[sep_pkg::CB_MID:sep_pkg::CB_LOW],
                                         ptr_q[7:0]};
                            end
                        end else if (st_q == sep_pkg::ST_ADDR) begin
                            ack_d = 1'b1;
                            ptr_d = {blk_q, sh_q};
                        end else begin
                            ack_d = 1'b1;
                            pbuf_d[ptr_q[3:0]] = sh_q;
                            vmask_d[ptr_q[3:0]] = 1'b1;
                            pend_d = 1'b1;
                            ptr_d = {ptr_q[AW-1:sep_pkg::PAGE_AW], ptr_q[3:0] + 4'h1};
                        end
                    end else if (scl_fall && cnt_q == sep_pkg::BIT_END) begin
                        ack_d = 1'b0;
                        cnt_d = 4'h0;
                        if (!ack_q) begin
                            st_d = sep_pkg::ST_IDLE;
                        end else if (st_q == sep_pkg::ST_CTRL) begin
                            if (sh_q[sep_pkg::CB_DIR]) begin
                                st_d = sep_pkg::ST_READ;
                                tx_d = mem_rd;
                            end else begin
                                st_d = sep_pkg::ST_ADDR;
                            end
                        end else begin
                            st_d = sep_pkg::ST_WDATA;
                        end
                    end
                end
            end
        endcase
        oe_d = ack_d || (st_d == sep_pkg::ST_READ && cnt_d < sep_pkg::BIT_ACK && !tx_d[7]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= sep_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'hFF;
            ack_q <= 1'b0;
            mack_q <= 1'b0;
            oe_q <= 1'b0;
            pend_q <= 1'b0;
            ptr_q <= 10'h000;
            blk_q <= 2'h0;
            vmask_q <= '0;
            pbuf_q <= '0;
            idx_q <= 4'h0;
            tmr_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ack_q <= ack_d;
            mack_q <= mack_d;
            oe_q <= oe_d;
            pend_q <= pend_d;
            ptr_q <= ptr_d;
            blk_q <= blk_d;
            vmask_q <= vmask_d;
            pbuf_q <= pbuf_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;

    // AXI4-Lite slave
    logic awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [sep_pkg::AXI_AW-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    sep_pkg::sep_stat_type stat;

    assign stat = '{ptr: ptr_q, wp: wp_eff, busy: busy};
    assign s_axi_awready = !awh_q && !bv_q;
    assign s_axi_wready = !wh_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;

    always_comb begin
        awh_d = awh_q;
        awa_d = awa_q;
        wh_d = wh_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        ctrl_d = ctrl_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awh_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wh_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (awh_q && wh_q) begin
            awh_d = 1'b0;
            wh_d = 1'b0;
            bv_d = 1'b1;
            br_d = sep_pkg::RESP_OK;
            if (reg_sel(awa_q) == sep_pkg::SEL_CTRL) begin
                if (ws_q[0]) begin
                    ctrl_d = wd_q[1:0];
                end
            end else if (reg_sel(awa_q) == sep_pkg::SEL_NONE) begin
                br_d = sep_pkg::RESP_ERR;
            end
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = sep_pkg::RESP_OK;
            if (reg_sel(s_axi_araddr) == sep_pkg::SEL_CTRL) begin
                rd_d = {30'h0, ctrl_q};
            end else if (reg_sel(s_axi_araddr) == sep_pkg::SEL_STAT) begin
                rd_d = 32'(stat);
            end else begin
                rd_d = 32'h0;
                rr_d = sep_pkg::RESP_ERR;
            end
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awh_q <= 1'b0;
            awa_q <= '0;
            wh_q <= 1'b0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= sep_pkg::RESP_OK;
            rv_q <= 1'b0;
            rd_q <= 32'h0;
            rr_q <= sep_pkg::RESP_OK;
            ctrl_q <= sep_pkg::CTRL_RST;
        end else begin
            awh_q <= awh_d;
            awa_q <= awa_d;
            wh_q <= wh_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            ctrl_q <= ctrl_d;
        end
    end
endmodule

// ### sep_core_tb_top.sv
// Self-checking bench for the serial EEPROM slave.
// Assumes the master model in sep_master and a pull-up on the data line.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("wrong value %s expected %0h seen %0h", n, e, s); end end
module sep_core_tb_top;
    localparam int LIMIT = 40000;
    // Arbitrary type code
    localparam logic [3:0] TYPE = 4'hA;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic scl_in, m_low, sda_out, sda_oe;
    logic wp_in = 1'b0;
    // Soft protect mirror and write strobe used by the bus tasks
    logic swp = 1'b0;
    logic [3:0] strb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] exp_mem [1024];
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    wire sda_in;
    assign sda_in = (sda_oe ? sda_out : 1'b1) && !m_low;
    always #25 aclk = ~aclk;
    sep_core #(.WRITE_CYCLES(200), .DEV_TYPE(TYPE)) u_sep_core (
        .aclk, .aresetn, .scl_in, .sda_in, .sda_out, .sda_oe, .wp_in,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp
    );
    sep_master u_sep_master (.clk(aclk), .sda(sda_in), .scl(scl_in), .pull_low(m_low));
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            if (s_axi_awready && !ta) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !tw) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    // Unused control bit 3 follows a[4] so both values are seen
    function automatic logic [7:0] ctl(input logic [9:0] a, input logic rd);
        return {TYPE, a[4], a[9:8], rd};
    endfunction
    task automatic wr(input logic [9:0] a, input int n, input logic [7:0] d0);
        logic k;
        int polls;
        u_sep_master.start();
        u_sep_master.tx(ctl(a, 1'b0), k);
        `CHK("ctl ack", 1'b1, k)
        u_sep_master.tx(a[7:0], k);
        `CHK("addr ack", 1'b1, k)
        for (int i = 0; i < n; i++) begin
            u_sep_master.tx(d0 + 8'(i), k);
            `CHK("data ack", 1'b1, k)
            if (!(wp_in || swp)) exp_mem[{a[9:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
        end
        u_sep_master.stop();
        polls = 0;
        k = 1'b0;
        while (!k && polls < 8) begin
            u_sep_master.start();
            u_sep_master.tx(ctl(a, 1'b0), k);
            u_sep_master.stop();
            polls++;
        end
        `CHK("busy nack", !(wp_in || swp), polls > 1)
        `CHK("poll ack", 1'b1, k)
    endtask
    task automatic rd(input logic [9:0] a, input int n, input logic cur);
        logic k, r;
        logic [7:0] d;
        if (!cur) begin
            u_sep_master.start();
            u_sep_master.tx(ctl(a, 1'b0), k);
            u_sep_master.tx(a[7:0], k);
            `CHK("addr ack", 1'b1, k)
        end
        u_sep_master.start();
        u_sep_master.tx(ctl(a, 1'b1), k);
        `CHK("read ctl ack", 1'b1, k)
        for (int i = 0; i < n; i++) begin
            u_sep_master.rx(i < n - 1, d, r);
            `CHK("read data", exp_mem[a + 10'(i)], d)
        end
        `CHK("released", 1'b1, r)
        u_sep_master.stop();
    endtask
    task automatic t_regs();
        axr(sep_pkg::REG_CTRL, 32'h1, sep_pkg::RESP_OK);
        axr(sep_pkg::REG_STAT, 32'h0, sep_pkg::RESP_OK);
        axr(4'h8, 32'h0, sep_pkg::RESP_ERR);
        axw(4'hC, 32'h3, sep_pkg::RESP_ERR);
        axw(sep_pkg::REG_STAT, 32'hF, sep_pkg::RESP_OK);
        axr(sep_pkg::REG_STAT, 32'h0, sep_pkg::RESP_OK);
        $display("test regs done");
    endtask
    task automatic t_page();
        wr(10'h23C, 18, 8'h40);
        rd(10'h230, 15, 1'b0);
        rd(10'h23F, 1, 1'b1);
        axr(sep_pkg::REG_STAT, 32'h900, sep_pkg::RESP_OK);
        $display("test page done");
    endtask
    task automatic t_wrap_wp();
        wr(10'h3FF, 1, 8'h5A);
        wr(10'h000, 1, 8'hA5);
        rd(10'h3FF, 2, 1'b0);
        @(posedge aclk);
        wp_in <= 1'b1;
        wr(10'h000, 1, 8'hEE);
        rd(10'h3FF, 2, 1'b0);
        @(posedge aclk);
        wp_in <= 1'b0;
        // Soft protect: pointer is 0x001 after the wrapped read
        swp = 1'b1;
        axw(sep_pkg::REG_CTRL, 32'h3, sep_pkg::RESP_OK);
        axr(sep_pkg::REG_STAT, 32'h6, sep_pkg::RESP_OK);
        wr(10'h3FF, 1, 8'h11);
        rd(10'h3FF, 2, 1'b0);
        // Strobe without byte 0 must leave the control bits alone
        strb = 4'hE;
        axw(sep_pkg::REG_CTRL, 32'h1, sep_pkg::RESP_OK);
        axr(sep_pkg::REG_CTRL, 32'h3, sep_pkg::RESP_OK);
        strb = 4'hF;
        axw(sep_pkg::REG_CTRL, 32'h1, sep_pkg::RESP_OK);
        swp = 1'b0;
        $display("test wrap and protect done");
    endtask
    task automatic t_refuse();
        logic k;
        u_sep_master.start();
        u_sep_master.tx({~TYPE, 4'h0}, k);
        u_sep_master.stop();
        `CHK("foreign code", 1'b0, k)
        axw(sep_pkg::REG_CTRL, 32'h0, sep_pkg::RESP_OK);
        axr(sep_pkg::REG_CTRL, 32'h0, sep_pkg::RESP_OK);
        u_sep_master.start();
        u_sep_master.tx(ctl(10'h0, 1'b1), k);
        u_sep_master.stop();
        `CHK("disabled", 1'b0, k)
        axw(sep_pkg::REG_CTRL, 32'h1, sep_pkg::RESP_OK);
        $display("test refuse done");
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_regs();
        t_page();
        t_wrap_wp();
        t_refuse();
        report_and_stop();
    end
endmodule

// ### sep_master.sv
// Behavioural two-wire bus master, 400 ns clock period.
// Assumes a pull-up on the data line outside; the clock stands high between frames.
`timescale 1ns/1ps
module sep_master (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic pull_low
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        hold(1);
        pull_low <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        pull_low <= 1'b1;
        hold(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        hold(1);
        pull_low <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        pull_low <= 1'b0;
        hold(4);
    endtask
    // Data moves a cycle after the fall, clear of the high phase
    task automatic clk_bit(input logic b, output logic r);
        hold(1);
        pull_low <= !b;
        hold(4);
        scl <= 1'b1;
        hold(3);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], r);
        end
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(input logic ack, output logic [7:0] d, output logic r);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(!ack, r);
    endtask
endmodule

// ### sep_mem.sv
// Byte array of the EEPROM, one write port and one registered read.
// Contents are not reset; the array models nonvolatile storage.
`timescale 1ns/1ps
module sep_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Access
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem_q [2**AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
        rdata_q <= mem_q[addr];
    end
endmodule

// ### sep_pkg.sv
// Constants, types and state encoding for the two-wire serial EEPROM slave.
// Assumes a 20 MHz aclk and an AXI4-Lite master for the side registers.
package sep_pkg;
    localparam int CLK_NS = 50;
    localparam int TWC_NS = 5000000;
    localparam int TWC_CYCLES = TWC_NS / CLK_NS;
    localparam int MEM_AW = 10;
    localparam int PAGE_AW = 4;
    localparam int PAGE_BYTES = 16;
    // Arbitrary neutral device type code
    localparam logic [3:0] DEV_CODE = 4'h5;
    localparam int CB_DIR = 0;
    localparam int CB_LOW = 1;
    localparam int CB_MID = 2;
    localparam int CB_CODE = 4;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam int AXI_AW = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_EN = 0;
    localparam int CTRL_SWP = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_STAT = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADDR, ST_WDATA, ST_READ, ST_COMMIT, ST_WAIT
    } sep_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } sep_line_type;

    typedef struct packed {
        logic [MEM_AW-1:0] ptr;
        logic wp;
        logic busy;
    } sep_stat_type;
endpackage

// ### sep_sva.sv
// Checker for the serial EEPROM slave, port relations only.
// Assumes the bench clocks scl far slower than aclk.
`timescale 1ns/1ps
module sep_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // AXI4-Lite
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    // Output moves only in the low phase, three syncs behind the fall
    property p_oe_in_low;
        $changed(sda_oe) |-> !$past(scl_in, 3);
    endproperty
    property p_ack_holds;
        $rose(sda_oe) |-> sda_oe [*6];
    endproperty
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    property p_b_timing;
        s_both_taken |=> s_b_answer;
    endproperty
    property p_b_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_aw_refused;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_r_timing;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_refused;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_oe_in_low: assert property (p_oe_in_low) else $error("data line moved in clock high");
    a_ack_holds: assert property (p_ack_holds) else $error("driven bit too short");
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    a_b_timing: assert property (p_b_timing) else $error("write response late");
    a_b_stands: assert property (p_b_stands) else $error("write response dropped");
    a_aw_refused: assert property (p_aw_refused) else $error("write taken while answering");
    a_r_timing: assert property (p_r_timing) else $error("read response late");
    a_r_stands: assert property (p_r_stands) else $error("read response dropped");
    a_ar_refused: assert property (p_ar_refused) else $error("read taken while answering");
endmodule
bind sep_core sep_sva u_sep_sva (
    .aclk, .aresetn, .scl_in, .sda_out, .sda_oe,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
